// ### vpdc_pkg.sv
package vpdc_pkg;

	// ------------------------------------------------------------
	// bus and register map
	// ------------------------------------------------------------
	localparam int VPDC_ADDR_W = 8;
	localparam int VPDC_DATA_W = 32;
	localparam logic [VPDC_ADDR_W-1:0] VPDC_OFS_VOLUME = 8'h00;
	localparam logic [VPDC_ADDR_W-1:0] VPDC_OFS_CONTROL = 8'h04;
	localparam logic [VPDC_ADDR_W-1:0] VPDC_OFS_SMP_LO = 8'h08;
	localparam logic [VPDC_ADDR_W-1:0] VPDC_OFS_SMP_HI = 8'h0C;
	localparam logic [VPDC_ADDR_W-1:0] VPDC_OFS_STATUS = 8'h10;
	localparam logic [1:0] VPDC_RESP_OKAY = 2'h0;
	localparam logic [1:0] VPDC_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int VPDC_VOL_UNMUTE_BIT = 7;
	localparam int VPDC_VOL_GAIN_W = 7;
	localparam int VPDC_CTL_AMP_BIT = 1;
	localparam int VPDC_CTL_DAC_BIT = 0;
	localparam int VPDC_CTL_W = 2;
	localparam logic [7:0] VPDC_VOLUME_RST = 8'h00;
	localparam logic [VPDC_CTL_W-1:0] VPDC_CONTROL_RST = 2'h0;
	localparam logic [7:0] VPDC_SMP_BYTE_RST = 8'h00;

	// status word: level in [3:0], flags above
	localparam int VPDC_ST_LEVEL_W = 4;
	localparam int VPDC_ST_EMPTY_BIT = 4;
	localparam int VPDC_ST_FULL_BIT = 5;
	localparam int VPDC_ST_DAC_BIT = 6;
	localparam int VPDC_ST_AMP_BIT = 7;
	localparam int VPDC_ST_SPK_BIT = 8;
	localparam int VPDC_ST_RSVD_BIT = 9;

	// ------------------------------------------------------------
	// sample path
	// ------------------------------------------------------------
	localparam int VPDC_SAMPLE_W = 16;
	localparam int VPDC_FIFO_DEPTH = 8;

	// ------------------------------------------------------------
	// gain code table, in half dB units
	// ------------------------------------------------------------
	localparam logic signed [7:0] VPDC_HALF_STEP_TOP = 8'sh0C;
	localparam logic signed [7:0] VPDC_HALF_STEP_BOT = -8'sh18;
	localparam logic signed [7:0] VPDC_FULL_STEP_TOP = -8'sh19;
	localparam logic signed [7:0] VPDC_FULL_STEP_BOT = -8'sh2C;
	localparam logic signed [7:0] VPDC_FULL_STEP_OFS = 8'sh0C;
	localparam logic signed [7:0] VPDC_GAIN_RSVD_HDB = -8'sh40;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic dac_en;
		logic amp_en;
		logic spk_drive;
	} vpdc_ctrl_t;

	typedef struct packed {
		logic [VPDC_VOL_GAIN_W-1:0] code;
		logic signed [7:0] half_db;
		logic reserved;
	} vpdc_gain_t;

endpackage : vpdc_pkg

// ### vpdc_fifo.sv
`timescale 1ns/10ps
module vpdc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	// fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	wire [AW-1:0] wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
	wire [AW-1:0] rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;

	assign in_ready = (count_r != FULL);
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign level = count_r;

	always_ff @(posedge aclk) begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_nxt;
			if (pop)
				rd_ptr_r <= rd_ptr_nxt;
			if (push != pop)
				count_r <= push ? count_r + 1'b1 : count_r - 1'b1;
		end
	end

endmodule : vpdc_fifo

// ### vpdc_gain_dec.sv
`timescale 1ns/10ps
module vpdc_gain_dec (
	// code from the volume register
	input wire logic [vpdc_pkg::VPDC_VOL_GAIN_W-1:0] code,
	// decoded gain
	output vpdc_pkg::vpdc_gain_t gain
);
	import vpdc_pkg::*;

	// code is read as a signed step count, which makes the wrap seamless
	wire signed [7:0] sc = {code[VPDC_VOL_GAIN_W-1], code};
	wire in_half = (sc <= VPDC_HALF_STEP_TOP) && (sc >= VPDC_HALF_STEP_BOT);
	wire in_full = (sc <= VPDC_FULL_STEP_TOP) && (sc >= VPDC_FULL_STEP_BOT);
	wire signed [7:0] full_hdb = 8'((sc + VPDC_FULL_STEP_OFS) <<< 1);

	// ------------------------------------------------------------
	// table lookup
	// ------------------------------------------------------------
	assign gain.code = code;
	assign gain.half_db = in_half ? sc : (in_full ? full_hdb : VPDC_GAIN_RSVD_HDB);
	// reserved codes fall to the quietest step rather than anything loud
	assign gain.reserved = !(in_half || in_full);

endmodule : vpdc_gain_dec

// ### vpdc_top.sv
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module vpdc_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [vpdc_pkg::VPDC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [vpdc_pkg::VPDC_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [vpdc_pkg::VPDC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [vpdc_pkg::VPDC_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// power management
	input wire logic pwr_down,
	// analogue controls
	output vpdc_pkg::vpdc_ctrl_t ana_ctrl,
	output vpdc_pkg::vpdc_gain_t ana_gain,
	// sample stream to the converter
	output logic [vpdc_pkg::VPDC_SAMPLE_W-1:0] dac_sample,
	output logic dac_sample_valid,
	input wire logic dac_sample_ready
);
	import vpdc_pkg::*;

	localparam int LVL_W = $clog2(VPDC_FIFO_DEPTH) + 1;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [7:0] volume_r;
	logic [VPDC_CTL_W-1:0] control_r;
	logic [7:0] smp_lo_r;
	logic [7:0] smp_hi_r;
	vpdc_ctrl_t ctrl_r;
	vpdc_gain_t gain_r;

	// ------------------------------------------------------------
	// write channel capture
	// ------------------------------------------------------------
	logic aw_full_r;
	logic w_full_r;
	logic [VPDC_ADDR_W-1:0] aw_addr_r;
	logic [VPDC_DATA_W-1:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;

	// address and data may come in either order; each is parked
	// until both are present and the response has been taken
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	assign s_axi_awready = !aw_full_r && !bvalid_r;
	assign s_axi_wready = !w_full_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire [VPDC_ADDR_W-1:0] wr_word = {aw_addr_r[VPDC_ADDR_W-1:2], 2'b00};
	wire wr_sel_vol = (wr_word == VPDC_OFS_VOLUME);
	wire wr_sel_ctl = (wr_word == VPDC_OFS_CONTROL);
	wire wr_sel_lo = (wr_word == VPDC_OFS_SMP_LO);
	wire wr_sel_hi = (wr_word == VPDC_OFS_SMP_HI);
	wire wr_sel_st = (wr_word == VPDC_OFS_STATUS);
	wire wr_mapped = wr_sel_vol | wr_sel_ctl | wr_sel_lo | wr_sel_hi | wr_sel_st;
	wire wr_lane0 = w_strb_r[0];

	// fifo back-pressure holds a high byte write until there is room
	logic fifo_in_ready;
	wire wr_ready_all = aw_full_r && w_full_r && !bvalid_r;
	wire wr_stall = wr_sel_hi && wr_lane0 && !fifo_in_ready;
	wire wr_do = wr_ready_all && !wr_stall;
	wire wr_vol = wr_do && wr_sel_vol && wr_lane0;
	wire wr_ctl = wr_do && wr_sel_ctl && wr_lane0;
	wire wr_lo = wr_do && wr_sel_lo && wr_lane0;
	wire wr_hi = wr_do && wr_sel_hi && wr_lane0;

	// ------------------------------------------------------------
	// write channel sequencing
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (aw_take) begin
			aw_full_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (w_take) begin
			w_full_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_do) begin
			w_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= VPDC_RESP_OKAY;
		end else if (wr_do) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? VPDC_RESP_OKAY : VPDC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			volume_r <= VPDC_VOLUME_RST;
			control_r <= VPDC_CONTROL_RST;
			smp_lo_r <= VPDC_SMP_BYTE_RST;
			smp_hi_r <= VPDC_SMP_BYTE_RST;
		end else begin
			if (wr_vol)
				volume_r <= w_data_r[7:0];
			if (wr_ctl)
				control_r <= w_data_r[VPDC_CTL_W-1:0];
			if (wr_lo)
				smp_lo_r <= w_data_r[7:0];
			if (wr_hi)
				smp_hi_r <= w_data_r[7:0];
		end
	end

	// ------------------------------------------------------------
	// sample commit
	// ------------------------------------------------------------
	// the whole word enters the fifo on the high byte write, so a
	// lone low byte write never shows up at the converter
	wire [VPDC_SAMPLE_W-1:0] commit_word = {w_data_r[7:0], smp_lo_r};
	wire commit_valid = wr_ready_all && wr_sel_hi && wr_lane0;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [VPDC_SAMPLE_W-1:0] fifo_out_data;
	logic [LVL_W-1:0] fifo_level;

	vpdc_fifo #(
		.WIDTH(VPDC_SAMPLE_W),
		.DEPTH(VPDC_FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_data(commit_word),
		.in_valid(commit_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.level(fifo_level)
	);

	// ------------------------------------------------------------
	// enables and gain
	// ------------------------------------------------------------
	wire unmute = volume_r[VPDC_VOL_UNMUTE_BIT];
	// power-down and mute outrank every enable bit
	wire run_ok = unmute && !pwr_down;
	wire dac_eff = control_r[VPDC_CTL_DAC_BIT] && run_ok;
	wire amp_eff = control_r[VPDC_CTL_AMP_BIT] && run_ok;
	wire spk_eff = dac_eff && amp_eff;
	vpdc_gain_t gain_dec;

	vpdc_gain_dec u_gain (
		.code(volume_r[VPDC_VOL_GAIN_W-1:0]),
		.gain(gain_dec)
	);

	// registered so decode glitches never reach the analogue side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= '0;
			gain_r <= '0;
		end else begin
			ctrl_r.dac_en <= dac_eff;
			ctrl_r.amp_en <= amp_eff;
			ctrl_r.spk_drive <= spk_eff;
			gain_r <= gain_dec;
		end
	end

	assign ana_ctrl = ctrl_r;
	assign ana_gain = gain_r;

	// ------------------------------------------------------------
	// sample stream out
	// ------------------------------------------------------------
	// a disabled converter drains nothing, so samples queue up
	assign dac_sample = fifo_out_data;
	assign dac_sample_valid = fifo_out_valid && ctrl_r.dac_en;
	assign fifo_out_ready = dac_sample_ready && ctrl_r.dac_en;

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	logic rvalid_r;
	logic [VPDC_DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	// low address bits are ignored, as on the write side
	wire [VPDC_ADDR_W-1:0] rd_word = {s_axi_araddr[VPDC_ADDR_W-1:2], 2'b00};
	wire rd_sel_vol = (rd_word == VPDC_OFS_VOLUME);
	wire rd_sel_ctl = (rd_word == VPDC_OFS_CONTROL);
	wire rd_sel_lo = (rd_word == VPDC_OFS_SMP_LO);
	wire rd_sel_hi = (rd_word == VPDC_OFS_SMP_HI);
	wire rd_sel_st = (rd_word == VPDC_OFS_STATUS);
	wire rd_mapped = rd_sel_vol | rd_sel_ctl | rd_sel_lo | rd_sel_hi | rd_sel_st;
	wire [VPDC_DATA_W-1:0] rd_vol = {24'h000000, volume_r};
	wire [VPDC_DATA_W-1:0] rd_ctl = {30'h0, control_r};
	wire [VPDC_DATA_W-1:0] rd_lo = {24'h000000, smp_lo_r};
	wire [VPDC_DATA_W-1:0] rd_hi = {24'h000000, smp_hi_r};

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	// a live view: reading it clears nothing, so polling is harmless
	wire [VPDC_DATA_W-1:0] rd_st;
	assign rd_st[VPDC_DATA_W-1:VPDC_ST_RSVD_BIT+1] = '0;
	assign rd_st[VPDC_ST_RSVD_BIT] = gain_r.reserved;
	assign rd_st[VPDC_ST_SPK_BIT] = ctrl_r.spk_drive;
	assign rd_st[VPDC_ST_AMP_BIT] = ctrl_r.amp_en;
	assign rd_st[VPDC_ST_DAC_BIT] = ctrl_r.dac_en;
	assign rd_st[VPDC_ST_FULL_BIT] = !fifo_in_ready;
	assign rd_st[VPDC_ST_EMPTY_BIT] = !fifo_out_valid;
	assign rd_st[VPDC_ST_LEVEL_W-1:0] = fifo_level;

	// ------------------------------------------------------------
	// read data select
	// ------------------------------------------------------------
	wire [VPDC_DATA_W-1:0] rd_mux =
		({VPDC_DATA_W{rd_sel_vol}} & rd_vol) |
		({VPDC_DATA_W{rd_sel_ctl}} & rd_ctl) |
		({VPDC_DATA_W{rd_sel_lo}} & rd_lo) |
		({VPDC_DATA_W{rd_sel_hi}} & rd_hi) |
		({VPDC_DATA_W{rd_sel_st}} & rd_st);

	// ------------------------------------------------------------
	// read response
	// ------------------------------------------------------------
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= VPDC_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_mapped ? VPDC_RESP_OKAY : VPDC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule : vpdc_top

// ### vpdc_sink.sv
`timescale 1ns/10ps
module vpdc_sink (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// stream from the block
	input wire logic [vpdc_pkg::VPDC_SAMPLE_W-1:0] sample,
	input wire logic valid,
	output logic ready,
	// pacing
	input wire logic slow
);
	import vpdc_pkg::*;
	logic [1:0] ph_r;
	// slow takes one word in three, so the fifo head must hold meanwhile
	always_ff @(posedge aclk) begin
		if (!aresetn) ph_r <= 2'h0;
		else ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
	end
	assign ready = !slow || (ph_r == 2'h0);
endmodule : vpdc_sink

// ### vpdc_top_checker.sv
`timescale 1ns/10ps
module vpdc_top_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// read channel
	input wire logic [vpdc_pkg::VPDC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [vpdc_pkg::VPDC_DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// controls and stream
	input wire logic pwr_down,
	input wire vpdc_pkg::vpdc_ctrl_t ana_ctrl,
	input wire vpdc_pkg::vpdc_gain_t ana_gain,
	input wire logic [vpdc_pkg::VPDC_SAMPLE_W-1:0] dac_sample,
	input wire logic dac_sample_valid,
	input wire logic dac_sample_ready
);
	import vpdc_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [VPDC_ADDR_W-1:0] raddr_r;
	logic signed [7:0] gs;
	assign gs = {ana_gain.code[6], ana_gain.code};
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) raddr_r <= s_axi_araddr;
	end
	AST_RST_OFF: assert property ($rose(aresetn) |-> ana_ctrl == '0 && ana_gain == '0)
		else $error("controls not cleared after reset");
	AST_SPK_ALL: assert property (ana_ctrl.spk_drive == (ana_ctrl.dac_en && ana_ctrl.amp_en))
		else $error("speaker drive without both enables");
	AST_PWR_OFF: assert property (pwr_down |=> !ana_ctrl.dac_en && !ana_ctrl.amp_en)
		else $error("enable survived power-down");
	AST_VALID_EN: assert property (dac_sample_valid |-> ana_ctrl.dac_en)
		else $error("stream active with converter off");
	AST_HEAD_HOLD: assert property (dac_sample_valid && !dac_sample_ready |=> $stable(dac_sample))
		else $error("stalled sample changed");
	AST_GAIN_HALF: assert property (gs >= -24 && gs <= 12 |-> ana_gain.half_db == gs && !ana_gain.reserved)
		else $error("half step gain wrong");
	AST_GAIN_FULL: assert property (gs >= -44 && gs <= -25 |-> ana_gain.half_db == 2 * (gs + 12))
		else $error("full step gain wrong");
	AST_GAIN_RSVD: assert property (gs > 12 || gs < -44 |-> ana_gain.reserved)
		else $error("reserved code not flagged");
	AST_CTL_ZERO: assert property (s_axi_rvalid && raddr_r == VPDC_OFS_CONTROL |-> s_axi_rdata[31:2] == '0)
		else $error("control upper bits read nonzero");
	AST_BYTE_ZERO: assert property (s_axi_rvalid && raddr_r < VPDC_OFS_STATUS |-> s_axi_rdata[31:8] == '0)
		else $error("byte register upper bits nonzero");
	cover property (ana_ctrl.spk_drive);
	cover property (dac_sample_valid && dac_sample_ready);
	cover property (ana_gain.reserved);
endmodule : vpdc_top_checker
bind vpdc_top vpdc_top_checker i_vpdc_top_checker (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pwr_down, .ana_ctrl, .ana_gain, .dac_sample,
	.dac_sample_valid, .dac_sample_ready);

// ### test_vpdc_top.sv
`timescale 1ns/10ps
module test_vpdc_top;
	import vpdc_pkg::*;
	logic aclk, aresetn, pwr_down, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rng, d;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	vpdc_ctrl_t ana_ctrl;
	vpdc_gain_t ana_gain;
	logic [15:0] dac_sample, s;
	logic dac_sample_valid, dac_sample_ready;
	logic [15:0] expq[$], got[$];
	int miscompares, check_count, i, n;
	vpdc_top i_vpdc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pwr_down, .ana_ctrl, .ana_gain, .dac_sample, .dac_sample_valid,
		.dac_sample_ready);
	vpdc_sink i_vpdc_sink (.aclk, .aresetn, .sample(dac_sample), .valid(dac_sample_valid),
		.ready(dac_sample_ready), .slow);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (aresetn && dac_sample_valid && dac_sample_ready) got.push_back(dac_sample);
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	function automatic logic [8:0] egain(input logic [6:0] c);
		int v;
		v = c[6] ? int'(c) - 128 : int'(c);
		if (v >= -24 && v <= 12) return {8'(v), 1'b0};
		if (v >= -44 && v < -24) return {8'(2 * (v + 12)), 1'b0};
		return {8'hC0, 1'b1};
	endfunction : egain
	function automatic logic [2:0] ectl(input logic [1:0] c, input logic u, input logic pd);
		logic en_d, en_a;
		en_d = c[0] & u & !pd;
		en_a = c[1] & u & !pd;
		return {en_d, en_a, en_d & en_a};
	endfunction : ectl
	task automatic test_done();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tmo(input logic t);
		if (t) begin
			miscompares++;
			test_done();
		end
	endtask : tmo
	task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && k < 200);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(k >= 200);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && k < 200);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(k >= 200);
	endtask : axr
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [1:0] rs;
		axw(a, wd, rs);
		chk("bresp", {30'h0, rs}, {30'h0, VPDC_RESP_OKAY});
	endtask : wr
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] rd;
		logic [1:0] rs;
		axr(a, rd, rs);
		chk(nm, rd, e);
		chk("rresp", {30'h0, rs}, {30'h0, VPDC_RESP_OKAY});
	endtask : rchk
	// controls are registered one edge behind the register state
	task automatic settle();
		repeat (2) @(posedge aclk);
		#1;
	endtask : settle
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{aresetn, pwr_down, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h08;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
		{miscompares, check_count, rng} = {32'h0, 32'h0, 32'h27};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 4; i++) rchk("reset_value", 8'(4 * i), 32'h0);
		settle();
		chk("ctrl_reset", {29'h0, ana_ctrl}, 32'h0);
		$display("test reset done");
		wr(VPDC_OFS_CONTROL, 32'hFFFFFFFF);
		rchk("control", VPDC_OFS_CONTROL, 32'h3);
		wr(VPDC_OFS_CONTROL, 32'hFFFFFFFE);
		rchk("control", VPDC_OFS_CONTROL, 32'h2);
		// byte lane 0 off must leave the register alone
		@(posedge aclk);
		s_axi_wstrb <= 4'hE;
		wr(VPDC_OFS_CONTROL, 32'h1);
		rchk("lane_off", VPDC_OFS_CONTROL, 32'h2);
		@(posedge aclk);
		s_axi_wstrb <= 4'hF;
		for (i = 0; i < 132; i++) begin
			d = (i < 128) ? i : xs();
			wr(VPDC_OFS_VOLUME, d);
			rchk("volume", VPDC_OFS_VOLUME, {24'h0, d[7:0]});
			settle();
			chk("gain", {16'h0, ana_gain}, {16'h0, d[6:0], egain(d[6:0])});
		end
		$display("test gain done");
		for (i = 0; i < 16; i++) begin
			@(posedge aclk);
			pwr_down <= i[3];
			wr(VPDC_OFS_CONTROL, {30'h0, i[1:0]});
			wr(VPDC_OFS_VOLUME, {24'h0, i[2], 7'h0});
			settle();
			chk("ctrl", {29'h0, ana_ctrl}, {29'h0, ectl(i[1:0], i[2], i[3])});
		end
		@(posedge aclk);
		pwr_down <= 1'b0;
		$display("test enables done");
		wr(VPDC_OFS_VOLUME, 32'h0);
		wr(VPDC_OFS_CONTROL, 32'h1);
		wr(VPDC_OFS_SMP_LO, 32'hA5);
		rchk("low_alone", VPDC_OFS_STATUS, 32'h10);
		for (i = 0; i < 8; i++) begin
			s = (i == 0) ? 16'hFFFF : 16'(xs());
			wr(VPDC_OFS_SMP_LO, {24'h0, s[7:0]});
			wr(VPDC_OFS_SMP_HI, {24'h0, s[15:8]});
			expq.push_back(s);
		end
		rchk("full_status", VPDC_OFS_STATUS, 32'h28);
		rchk("low_byte", VPDC_OFS_SMP_LO, {24'h0, s[7:0]});
		rchk("high_byte", VPDC_OFS_SMP_HI, {24'h0, s[15:8]});
		// unmuted but powered down: the queue must stay put
		@(posedge aclk);
		pwr_down <= 1'b1;
		wr(VPDC_OFS_VOLUME, 32'h80);
		rchk("pd_status", VPDC_OFS_STATUS, 32'h28);
		// a ninth sample stalls on the full queue until power returns
		s = 16'h8001;
		expq.push_back(s);
		fork
			begin
				wr(VPDC_OFS_SMP_LO, {24'h0, s[7:0]});
				wr(VPDC_OFS_SMP_HI, {24'h0, s[15:8]});
			end
			begin
				repeat (30) @(posedge aclk);
				pwr_down <= 1'b0;
			end
		join
		n = 0;
		while (got.size() < 9 && n < 500) begin
			@(posedge aclk);
			n++;
		end
		tmo(n >= 500);
		for (i = 0; i < 9; i++) chk("sample", {16'h0, got[i]}, {16'h0, expq[i]});
		rchk("empty_status", VPDC_OFS_STATUS, 32'h50);
		$display("test stream done");
		wr(VPDC_OFS_CONTROL, 32'h3);
		wr(VPDC_OFS_SMP_LO, 32'h5A);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 4; i++) rchk("rerun_value", 8'(4 * i), 32'h0);
		settle();
		chk("ctrl_rerun", {29'h0, ana_ctrl}, 32'h0);
		$display("test mid reset done");
		axw(8'h20, xs(), r);
		chk("unmapped_bresp", {30'h0, r}, {30'h0, VPDC_RESP_SLVERR});
		axr(8'h20, d, r);
		chk("unmapped_rdata", d, 32'h0);
		chk("unmapped_rresp", {30'h0, r}, {30'h0, VPDC_RESP_SLVERR});
		$display("test unmapped done");
		test_done();
	end
endmodule : test_vpdc_top
